// File: logic/pes_core.sv
/*
  pwm event source selection, time base and auto-shutdown controller with AHB-Lite registers.
  assumes pin and comparator inputs are asynchronous; one clock sys_clk, reset rst_n.
*/
// Decided for this implementation: the AHB-Lite slave port and the register offsets.
`timescale 1ns/10ps
module pes_core
  import pes_pkg::*;
#(
  parameter int CNT_W = 16,
  parameter bit SECOND_INST = 1'b0
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic external_event_input,
  input wire logic [3:0] comparator_in,
  input wire logic [5:0] pwm_in,
  output logic [5:0] pwm_out,
  output logic [CNT_W-1:0] time_base_counter,
  output logic falling_event,
  output logic period_event,
  output logic shutdown_irq_flag
);
  localparam logic [7:0] LVL_MASK = SECOND_INST ? PES_LVL_MASK_AB : PES_LVL_MASK_FULL;

  logic [7:0] falling_event_source_select;
  logic [7:0] period_event_source_select;
  logic [7:0] shutdown_control;
  logic [7:0] shutdown_output_levels;
  logic [7:0] shutdown_source_select;
  logic event_input_polarity;
  logic [CNT_W-1:0] duty_value;
  logic [CNT_W-1:0] period_value;
  logic [4:0] sync1;
  logic [4:0] sync2;
  pes_src_s src;
  logic wr_pend;
  logic [31:0] wr_addr;
  logic sw_clear;
  logic sw_set;
  logic sw_irq_clear;
  logic fall_hit;
  logic per_hit;
  logic sd_cond;
  logic sd_trip;
  logic sd_ovr;
  logic next_status;

  function automatic logic [7:0] read_reg(input logic [31:0] a);
    logic [7:0] r;
    r = 8'h00;
    case (a)
      PES_OFS_FALL: r = falling_event_source_select;
      PES_OFS_PER: r = period_event_source_select;
      PES_OFS_SDCTL: r = shutdown_control;
      PES_OFS_SDLVL: r = shutdown_output_levels;
      PES_OFS_SDSRC: r = shutdown_source_select;
      PES_OFS_POL: r = {7'h00, event_input_polarity};
      PES_OFS_STAT: r = {7'h00, shutdown_irq_flag};
      default: r = 8'h00;
    endcase
    return r;
  endfunction

  // two-flop synchronisers
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1 <= 5'h00;
      sync2 <= 5'h00;
    end else begin
      sync1 <= {external_event_input, comparator_in};
      sync2 <= sync1;
    end
  end

  // level sources, polarity applied to pin
  always_comb begin
    src.pin = sync2[4] ^ event_input_polarity;
    src.cmp = sync2[3:0];
  end

  // bus address phase capture
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_pend <= 1'b0;
      wr_addr <= 32'h0000_0000;
    end else begin
      wr_pend <= hsel && hready && htrans == HTRANS_NONSEQ && hwrite;
      if (hsel && hready && htrans == HTRANS_NONSEQ) begin
        wr_addr <= {haddr[31:2], 2'b00};
      end
    end
  end

  // bus answer: zero wait states, always okay
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (hsel && hready && htrans == HTRANS_NONSEQ && !hwrite) begin
        hrdata <= {24'h000000, read_reg({haddr[31:2], 2'b00})};
      end
    end
  end

  assign sw_clear = wr_pend && wr_addr == PES_OFS_SDCTL && !hwdata[PES_BIT_STATUS];
  assign sw_set = wr_pend && wr_addr == PES_OFS_SDCTL && hwdata[PES_BIT_STATUS];
  assign sw_irq_clear = wr_pend && wr_addr == PES_OFS_STAT && hwdata[0];

  // configuration registers
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      falling_event_source_select <= PES_REG_RESET;
      period_event_source_select <= PES_REG_RESET;
      shutdown_output_levels <= PES_REG_RESET;
      shutdown_source_select <= PES_REG_RESET;
      event_input_polarity <= 1'b0;
      duty_value <= '0;
      period_value <= '0;
    end else if (wr_pend) begin
      case (wr_addr)
        PES_OFS_FALL: falling_event_source_select <= hwdata[7:0] & PES_SRC_MASK;
        PES_OFS_PER: period_event_source_select <= hwdata[7:0] & PES_SRC_MASK;
        PES_OFS_SDLVL: shutdown_output_levels <= hwdata[7:0] & LVL_MASK;
        PES_OFS_SDSRC: shutdown_source_select <= hwdata[7:0] & PES_SDSRC_MASK;
        PES_OFS_POL: event_input_polarity <= hwdata[0];
        PES_OFS_DUTY: duty_value <= hwdata[CNT_W-1:0];
        PES_OFS_PERIOD: period_value <= hwdata[CNT_W-1:0];
        default: ;
      endcase
    end
  end

  // event source combination
  always_comb begin
    fall_hit = (falling_event_source_select[PES_BIT_PIN] && src.pin)
      || |(falling_event_source_select[4:1] & src.cmp)
      || (falling_event_source_select[PES_BIT_MATCH] && time_base_counter == duty_value);
    per_hit = (period_event_source_select[PES_BIT_PIN] && src.pin)
      || |(period_event_source_select[4:1] & src.cmp)
      || (period_event_source_select[PES_BIT_MATCH] && time_base_counter == period_value);
  end

  // time base
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      time_base_counter <= PES_CNT_RESET;
      falling_event <= 1'b0;
      period_event <= 1'b0;
    end else begin
      falling_event <= fall_hit;
      period_event <= per_hit;
      if (per_hit) begin
        time_base_counter <= PES_CNT_RESET;
      end else begin
        time_base_counter <= time_base_counter + 1'b1;
      end
    end
  end

  // shutdown condition
  always_comb begin
    sd_cond = (shutdown_source_select[PES_BIT_PIN] && src.pin) || |(shutdown_source_select[4:1] & src.cmp);
    sd_ovr = shutdown_control[PES_BIT_SDEN] && shutdown_control[PES_BIT_OVR];
    sd_trip = shutdown_control[PES_BIT_SDEN] && (sd_cond || sd_ovr);
    next_status = shutdown_control[PES_BIT_STATUS];
    if (sw_clear) begin
      next_status = 1'b0;
    end
    if (shutdown_control[PES_BIT_ARS] && !sd_trip) begin
      next_status = 1'b0;
    end
    if (sw_set) begin
      next_status = 1'b1;
    end
    if (sd_trip) begin
      next_status = 1'b1;
    end
  end

  // shutdown control register and status
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      shutdown_control <= PES_REG_RESET;
    end else begin
      shutdown_control[PES_BIT_STATUS] <= next_status;
      if (wr_pend && wr_addr == PES_OFS_SDCTL) begin
        shutdown_control[6:0] <= hwdata[6:0] & PES_SDCTL_MASK[6:0];
      end
    end
  end

  // irq flag: hardware set wins over software clear
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      shutdown_irq_flag <= 1'b0;
    end else if (shutdown_control[PES_BIT_SDEN] && sd_cond && !sd_ovr) begin
      shutdown_irq_flag <= 1'b1;
    end else if (sw_irq_clear) begin
      shutdown_irq_flag <= 1'b0;
    end
  end

  // output steering
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pwm_out <= 6'h00;
    end else if (next_status) begin
      pwm_out <= shutdown_output_levels[5:0];
    end else begin
      pwm_out <= pwm_in;
    end
  end

  property p_fall_pin;
    @(posedge sys_clk) disable iff (!rst_n)
    (falling_event_source_select[PES_BIT_PIN] && src.pin) |=> falling_event;
  endproperty
  a_fall_pin: assert property (p_fall_pin) else $error("pin fall event missing");

  property p_fall_none;
    @(posedge sys_clk) disable iff (!rst_n)
    (falling_event_source_select == 8'h00) |=> !falling_event;
  endproperty
  a_fall_none: assert property (p_fall_none) else $error("fall event without source");

  property p_per_reset;
    @(posedge sys_clk) disable iff (!rst_n)
    period_event |-> time_base_counter == 16'h0000;
  endproperty
  a_per_reset: assert property (p_per_reset) else $error("counter not reset");

  property p_per_match;
    @(posedge sys_clk) disable iff (!rst_n)
    (period_event_source_select[PES_BIT_MATCH] && time_base_counter == period_value) |=> period_event;
  endproperty
  a_per_match: assert property (p_per_match) else $error("period match missed");

  property p_levels;
    @(posedge sys_clk) disable iff (!rst_n)
    shutdown_control[PES_BIT_STATUS] |-> pwm_out == $past(shutdown_output_levels[5:0]);
  endproperty
  a_levels: assert property (p_levels) else $error("shutdown level wrong");

  property p_trip;
    @(posedge sys_clk) disable iff (!rst_n)
    (shutdown_control[PES_BIT_SDEN] && sd_cond && !sd_ovr)
      |=> shutdown_control[PES_BIT_STATUS] && shutdown_irq_flag;
  endproperty
  a_trip: assert property (p_trip) else $error("shutdown not taken");

  property p_no_en;
    @(posedge sys_clk) disable iff (!rst_n)
    (!shutdown_control[PES_BIT_SDEN] && !sw_set && !shutdown_control[PES_BIT_STATUS])
      |=> !shutdown_control[PES_BIT_STATUS];
  endproperty
  a_no_en: assert property (p_no_en) else $error("shutdown while disabled");

  property p_hold;
    @(posedge sys_clk) disable iff (!rst_n)
    (shutdown_control[PES_BIT_STATUS] && !shutdown_control[PES_BIT_ARS] && !sw_clear)
      |=> shutdown_control[PES_BIT_STATUS];
  endproperty
  a_hold: assert property (p_hold) else $error("status dropped");

  property p_restart;
    @(posedge sys_clk) disable iff (!rst_n)
    (shutdown_control[PES_BIT_ARS] && !sd_trip && !sw_set) |=> !shutdown_control[PES_BIT_STATUS];
  endproperty
  a_restart: assert property (p_restart) else $error("no auto restart");

  property p_unimpl;
    @(posedge sys_clk) disable iff (!rst_n)
    (falling_event_source_select[6:5] == 2'b00) && (shutdown_control[4:1] == 4'h0);
  endproperty
  a_unimpl: assert property (p_unimpl) else $error("unimplemented bit set");

  property p_normal;
    @(posedge sys_clk) disable iff (!rst_n)
    (!shutdown_control[PES_BIT_STATUS] && $past(rst_n)) |-> pwm_out == $past(pwm_in);
  endproperty
  a_normal: assert property (p_normal) else $error("outputs not passed through");

  property p_fall_cmp;
    @(posedge sys_clk) disable iff (!rst_n)
    (|(falling_event_source_select[4:1] & src.cmp)) |=> falling_event;
  endproperty
  a_fall_cmp: assert property (p_fall_cmp) else $error("comparator fall event missing");

  property p_per_pin;
    @(posedge sys_clk) disable iff (!rst_n)
    (period_event_source_select[PES_BIT_PIN] && src.pin) |=> period_event && time_base_counter == PES_CNT_RESET;
  endproperty
  a_per_pin: assert property (p_per_pin) else $error("pin period event missing");

  property p_per_none;
    @(posedge sys_clk) disable iff (!rst_n)
    (period_event_source_select == 8'h00) |=> !period_event;
  endproperty
  a_per_none: assert property (p_per_none) else $error("period event without source");

  property p_ovr_irq;
    @(posedge sys_clk) disable iff (!rst_n)
    (sd_ovr && !sd_cond && !shutdown_irq_flag) |=> shutdown_control[PES_BIT_STATUS] && !shutdown_irq_flag;
  endproperty
  a_ovr_irq: assert property (p_ovr_irq) else $error("override behaviour wrong");

  property p_sw_set;
    @(posedge sys_clk) disable iff (!rst_n)
    sw_set |=> shutdown_control[PES_BIT_STATUS];
  endproperty
  a_sw_set: assert property (p_sw_set) else $error("software shutdown not taken");

  property p_hw_wins;
    @(posedge sys_clk) disable iff (!rst_n)
    (sd_trip && sw_clear) |=> shutdown_control[PES_BIT_STATUS];
  endproperty
  a_hw_wins: assert property (p_hw_wins) else $error("software clear beat hardware set");

  property p_irq_clear;
    @(posedge sys_clk) disable iff (!rst_n)
    (sw_irq_clear && !(shutdown_control[PES_BIT_SDEN] && sd_cond && !sd_ovr)) |=> !shutdown_irq_flag;
  endproperty
  a_irq_clear: assert property (p_irq_clear) else $error("irq flag not cleared");

  property p_counter;
    @(posedge sys_clk) disable iff (!rst_n)
    !per_hit |=> time_base_counter == $past(time_base_counter) + 1'b1;
  endproperty
  a_counter: assert property (p_counter) else $error("time base did not count");

  property p_lvl_mask;
    @(posedge sys_clk) disable iff (!rst_n)
    (shutdown_output_levels & ~LVL_MASK) == 8'h00;
  endproperty
  a_lvl_mask: assert property (p_lvl_mask) else $error("absent level bit set");

  c_fall: cover property (@(posedge sys_clk) disable iff (!rst_n) falling_event);
  c_per: cover property (@(posedge sys_clk) disable iff (!rst_n) period_event);
  c_sd: cover property (@(posedge sys_clk) disable iff (!rst_n) shutdown_irq_flag);
  c_rs: cover property (@(posedge sys_clk) disable iff (!rst_n)
    shutdown_control[PES_BIT_STATUS] ##1 !shutdown_control[PES_BIT_STATUS]);
  c_ovr: cover property (@(posedge sys_clk) disable iff (!rst_n) sd_ovr && shutdown_control[PES_BIT_STATUS]);
endmodule

// File: logic/pes_pkg.sv
/*
  package for the pwm event source and shutdown block: register map, field positions, reset values.
  assumes a single 100 MHz clock domain and an AHB-Lite register bus.
*/
package pes_pkg;
  localparam logic [31:0] PES_OFS_FALL = 32'h0000_0000;
  localparam logic [31:0] PES_OFS_PER = 32'h0000_0004;
  localparam logic [31:0] PES_OFS_SDCTL = 32'h0000_0008;
  localparam logic [31:0] PES_OFS_SDLVL = 32'h0000_000c;
  localparam logic [31:0] PES_OFS_SDSRC = 32'h0000_0010;
  localparam logic [31:0] PES_OFS_POL = 32'h0000_0014;
  localparam logic [31:0] PES_OFS_DUTY = 32'h0000_0018;
  localparam logic [31:0] PES_OFS_PERIOD = 32'h0000_001c;
  localparam logic [31:0] PES_OFS_STAT = 32'h0000_0020;
  localparam logic [7:0] PES_SRC_MASK = 8'h9f;
  localparam logic [7:0] PES_SDSRC_MASK = 8'h9e;
  localparam logic [7:0] PES_SDCTL_MASK = 8'he1;
  localparam logic [7:0] PES_LVL_MASK_FULL = 8'h3f;
  localparam logic [7:0] PES_LVL_MASK_AB = 8'h03;
  localparam int PES_BIT_PIN = 7;
  localparam int PES_BIT_MATCH = 0;
  localparam int PES_BIT_STATUS = 7;
  localparam int PES_BIT_SDEN = 6;
  localparam int PES_BIT_ARS = 5;
  localparam int PES_BIT_OVR = 0;
  localparam logic [7:0] PES_REG_RESET = 8'h00;
  localparam logic [15:0] PES_CNT_RESET = 16'h0000;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  typedef struct packed {
    logic pin;
    logic [3:0] cmp;
  } pes_src_s;
endpackage

// File: verification/pes_fault_src.sv
/*
  model of the far side: external event pin and four comparator outputs.
  assumes the bench requests levels through a packed source struct.
*/
`timescale 1ns/10ps
module pes_fault_src
  import pes_pkg::*;
(
  input wire logic sys_clk,
  input wire pes_src_s src_req,
  output logic external_event_input,
  output logic [3:0] comparator_in
);
  initial begin
    external_event_input = 1'b0;
    comparator_in = 4'h0;
  end
  // levels change just after the edge, async to the block
  always @(posedge sys_clk) begin
    external_event_input <= src_req.pin;
    comparator_in <= src_req.cmp;
  end
endmodule

// File: verification/tb_pwm_event_source_and_shutdown.sv
/*
  self-checking bench: register access over AHB-Lite, event sources, shutdown.
  assumes pes_core with default parameters and the fault source model.
*/
`timescale 1ns/10ps
`define CHK(nm, e, s) begin comparisons++; if ((s) !== (e)) begin n_mismatch++; \
  $display("wrong value %s expected %h seen %h", nm, e, s); end end
module tb_pwm_event_source_and_shutdown;
  import pes_pkg::*;
  logic sys_clk, rst_n, hsel, hwrite, hreadyout, hresp, ext_in, fall_ev, per_ev, irq;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [3:0] cmp_in;
  logic [5:0] pwm_in, pwm_out;
  logic [15:0] tbc, c;
  logic [7:0] m;
  pes_src_s req;
  int n_mismatch, comparisons;
  logic [31:0] ofs[4] = '{PES_OFS_FALL, PES_OFS_PER, PES_OFS_SDCTL, PES_OFS_SDLVL};
  logic [7:0] wv[4] = '{8'hff, 8'hff, 8'h3f, 8'hff};
  logic [7:0] ev[4] = '{PES_SRC_MASK, PES_SRC_MASK, 8'h21, PES_LVL_MASK_FULL};

  pes_core i_pes_core (.sys_clk(sys_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .external_event_input(ext_in),
    .comparator_in(cmp_in), .pwm_in(pwm_in), .pwm_out(pwm_out), .time_base_counter(tbc),
    .falling_event(fall_ev), .period_event(per_ev), .shutdown_irq_flag(irq));
  pes_fault_src i_pes_fault_src (.sys_clk(sys_clk), .src_req(req),
    .external_event_input(ext_in), .comparator_in(cmp_in));

  task final_report;
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task rdy;
    int i;
    i = 0;
    @(posedge sys_clk);
    while (hreadyout !== 1'b1) begin
      i++;
      if (i > 20) begin
        n_mismatch++;
        final_report;
      end
      @(posedge sys_clk);
    end
  endtask

  task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    haddr <= a;
    hwrite <= w;
    hsize <= 3'h2;
    rdy;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    rdy;
  endtask

  task wr(input logic [31:0] a, input logic [7:0] d);
    bus(1'b1, a, {24'h0, d});
  endtask

  task rdc(input logic [31:0] a, input logic [7:0] e);
    bus(1'b0, a, 32'h0);
    `CHK("read data", {24'h0, e}, hrdata)
    `CHK("hresp", 1'b0, hresp)
  endtask

  task src(input int j, input logic v);
    @(posedge sys_clk);
    if (j == 4) req.pin <= v;
    else req.cmp[j] <= v;
  endtask

  task ev_wait(input bit per, input logic e, input int n);
    logic seen;
    seen = 1'b0;
    c = 16'hffff;
    repeat (n) begin
      @(posedge sys_clk);
      #1;
      if ((per ? per_ev : fall_ev) === 1'b1 && !seen) begin
        seen = 1'b1;
        c = tbc;
      end
    end
    `CHK("event", e, seen)
  endtask

  task so(input logic [5:0] e);
    repeat (6) @(posedge sys_clk);
    #1;
    `CHK("pwm_out", e, pwm_out)
  endtask

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  initial begin
    n_mismatch = 0;
    comparisons = 0;
    rst_n = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    req = '0;
    pwm_in = 6'h15;
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'b1;
    for (int k = 0; k < 4; k++) begin
      rdc(ofs[k], 8'h00);
      wr(ofs[k], wv[k]);
      rdc(ofs[k], ev[k]);
      wr(ofs[k], 8'h00);
    end
    rdc(32'h0000_0040, 8'h00);
    for (int p = 0; p < 2; p++) begin
      for (int j = 0; j < 5; j++) begin
        m = (j == 4) ? 8'h80 : 8'h02 << j;
        wr(ofs[p], m);
        src(j, 1'b1);
        ev_wait(p, 1'b1, 8);
        src(j, 1'b0);
        wr(ofs[p], 8'h9e & ~m);
        src(j, 1'b1);
        ev_wait(p, 1'b0, 8);
        src(j, 1'b0);
        wr(ofs[p], 8'h00);
      end
    end
    wr(PES_OFS_FALL, 8'h80);
    wr(PES_OFS_POL, 8'h01);
    ev_wait(0, 1'b1, 8);
    wr(PES_OFS_POL, 8'h00);
    wr(PES_OFS_FALL, 8'h12);
    src(0, 1'b1);
    src(3, 1'b1);
    ev_wait(0, 1'b1, 8);
    src(0, 1'b0);
    src(3, 1'b0);
    wr(PES_OFS_FALL, 8'h00);
    wr(PES_OFS_PERIOD, 8'd20);
    wr(PES_OFS_POL, 8'h01);
    wr(PES_OFS_PER, 8'h81);
    wr(PES_OFS_POL, 8'h00);
    ev_wait(1, 1'b1, 40);
    `CHK("counter", 16'h0000, c)
    ev_wait(1, 1'b0, 1);
    ev_wait(1, 1'b1, 1);
    wr(PES_OFS_DUTY, 8'd5);
    wr(PES_OFS_FALL, 8'h01);
    ev_wait(0, 1'b1, 40);
    wr(PES_OFS_FALL, 8'h00);
    ev_wait(0, 1'b0, 40);
    wr(PES_OFS_PER, 8'h00);
    ev_wait(1, 1'b0, 40);
    wr(PES_OFS_SDSRC, 8'h80);
    wr(PES_OFS_SDLVL, 8'h2a);
    src(4, 1'b1);
    so(6'h15);
    wr(PES_OFS_SDCTL, 8'h40);
    so(6'h2a);
    `CHK("irq", 1'b1, irq)
    rdc(PES_OFS_SDCTL, 8'hc0);
    src(4, 1'b0);
    so(6'h2a);
    wr(PES_OFS_SDCTL, 8'h40);
    so(6'h15);
    wr(PES_OFS_SDCTL, 8'h60);
    src(4, 1'b1);
    so(6'h2a);
    src(4, 1'b0);
    so(6'h15);
    wr(PES_OFS_STAT, 8'h01);
    wr(PES_OFS_SDCTL, 8'h41);
    so(6'h2a);
    `CHK("irq", 1'b0, irq)
    wr(PES_OFS_SDCTL, 8'h01);
    rdc(PES_OFS_SDCTL, 8'h81);
    wr(PES_OFS_SDCTL, 8'h01);
    so(6'h15);
    wr(PES_OFS_SDCTL, 8'h80);
    so(6'h2a);
    final_report;
  end
endmodule
